// ===== design/trc_pkg.sv
// Package of constants for the transceiver reset control block
package trc_pkg;
  // ****************************************************************
  // Register map (printed offsets are not all multiples of four)
  // ****************************************************************
  localparam int unsigned SOFT_RESET_IDX   = 32'h0000002a;
  localparam int unsigned RADIO_CTRL_IDX   = 32'h00000036;
  localparam int unsigned CHANNEL_CFG_IDX  = 32'h00000200;
  localparam int unsigned RESET_STATUS_IDX = 32'h00000300;
  localparam logic [11:0] SOFT_RESET_ADDR   = 12'(SOFT_RESET_IDX * 4);
  localparam logic [11:0] RADIO_CTRL_ADDR   = 12'(RADIO_CTRL_IDX * 4);
  localparam logic [11:0] CHANNEL_CFG_ADDR  = 12'(CHANNEL_CFG_IDX * 4);
  localparam logic [11:0] RESET_STATUS_ADDR = 12'(RESET_STATUS_IDX * 4);

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned MAC_RST_POS   = 0;
  localparam int unsigned BB_RST_POS    = 1;
  localparam int unsigned PWR_RST_POS   = 2;
  localparam int unsigned RFSM_RST_POS  = 2;
  localparam logic [7:0]  SOFT_RST_MASK = 8'h07;
  localparam logic [7:0]  RADIO_MASK    = 8'h1f;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RADIO_CTRL_RST  = 8'h00;
  localparam logic [7:0] CHANNEL_CFG_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned RELEASE_US       = 250;
  localparam int unsigned RELEASE_CYCLES   = RELEASE_US * CLK_MHZ;
  localparam int unsigned PULSE_CYCLES     = 4;

  // Sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    TRC_HOLD  = 2'b00,
    TRC_WAIT  = 2'b01,
    TRC_RUN   = 2'b11
  } trc_state_e;
endpackage : trc_pkg

// ===== design/trc_pulse_stretch.sv
// One-shot reset pulse stretcher for a circuit domain
`timescale 1ns/100ps
module trc_pulse_stretch #(
  parameter int unsigned LEN = 4
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      rst_o
);
  localparam int unsigned CW = $clog2(LEN + 1);
  logic [CW-1:0] cnt_q;

  // Load on start, count down to zero
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= CW'(LEN);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  assign rst_o = (cnt_q != '0);
endmodule : trc_pulse_stretch

// ===== design/trc_reset_ctrl.sv
// Transceiver reset control: pin, software and radio state machine resets
//
// Overview of operation
// - Power-up brings every control register to its reset value with no host action.
// - Driving the reset pin low resets all control registers for as long as it is low.
// - The device leaves reset about 250 us after the reset pin is released.
// - Writing one to software reset bit 2 resets power management only, registers kept.
// - Writing one to software reset bit 1 resets the baseband, registers kept.
// - Writing one to software reset bit 0 resets the MAC and all control registers.
// - The software reset bits act singly or together and clear themselves.
// - Host accesses are accepted straight after a software reset.
// - Writing one then zero to radio control bit 2 resets the radio state machine.
`timescale 1ns/100ps
module trc_reset_ctrl
  import trc_pkg::*;
#(
  parameter int unsigned RELEASE_CNT = trc_pkg::RELEASE_CYCLES,
  parameter int unsigned PULSE_LEN   = trc_pkg::PULSE_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             dev_ready_o,
  output logic             pwr_rst_o,
  output logic             bb_rst_o,
  output logic             mac_rst_o,
  output logic             rfsm_rst_o,
  output logic      [7:0]  channel_cfg_o,
  output logic      [1:0]  radio_mode_o,
  output logic      [1:0]  wake_count_hi_o
);
  import trc_pkg::*;

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic comb_n;
  logic sync1_q;
  logic sync2_q;
  logic sys_rst_n;

  // Power-on or pin reset asserts asynchronously
  assign comb_n = nrst_i & ext_reset_n_i;

  // Release passes two flops before use
  always_ff @(posedge core_clk_i or negedge comb_n) begin
    if (!comb_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= 1'b1;
      sync2_q <= sync1_q;
    end
  end
  assign sys_rst_n = sync2_q;

  // ****************************************************************
  // Release delay sequencer
  // ****************************************************************
  localparam int unsigned RW = $clog2(RELEASE_CNT + 1);
  trc_state_e    state_q;
  logic [RW-1:0] rel_cnt_q;

  // Hold the device in reset for the release delay
  always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_q   <= TRC_HOLD;
      rel_cnt_q <= '0;
    end else begin
      case (state_q)
        TRC_HOLD: begin
          state_q   <= TRC_WAIT;
          rel_cnt_q <= '0;
        end
        TRC_WAIT: begin
          if (rel_cnt_q == RW'(RELEASE_CNT - 1)) begin
            state_q <= TRC_RUN;
          end else begin
            rel_cnt_q <= rel_cnt_q + RW'(1);
          end
        end
        TRC_RUN: begin
          state_q <= TRC_RUN;
        end
        default: begin
          state_q <= TRC_HOLD;
        end
      endcase
    end
  end
  assign dev_ready_o = (state_q == TRC_RUN);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic        ap_wr_q;
  logic        ap_rd_q;
  logic [11:0] ap_addr_q;
  logic        take;

  // Accesses are only taken once out of reset
  assign take = hsel & hready & htrans[1] & dev_ready_o;

  // Capture the address phase
  always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= '0;
    end else begin
      ap_wr_q <= take & hwrite;
      ap_rd_q <= take & ~hwrite;
      if (take) begin
        ap_addr_q <= haddr[11:0];
      end
    end
  end

  // Zero wait states, always OKAY; no stall after a soft reset
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction : hit

  logic wr_soft;
  logic wr_radio;
  logic wr_chan;
  assign wr_soft  = ap_wr_q & hit(ap_addr_q, SOFT_RESET_ADDR);
  assign wr_radio = ap_wr_q & hit(ap_addr_q, RADIO_CTRL_ADDR);
  assign wr_chan  = ap_wr_q & hit(ap_addr_q, CHANNEL_CFG_ADDR);

  // ****************************************************************
  // Software resets
  // ****************************************************************
  logic [2:0] soft_go;
  logic [2:0] circ_rst;
  logic       mac_rst_n;

  // Any combination of bits in one write
  assign soft_go = wr_soft ? hwdata[2:0] : 3'b000;

  // Self-clearing reset pulses per circuit
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_soft
      trc_pulse_stretch #(
        .LEN (PULSE_LEN)
      ) u_stretch (
        .core_clk_i (core_clk_i),
        .nrst_i     (sys_rst_n),
        .start_i    (soft_go[g]),
        .rst_o      (circ_rst[g])
      );
    end
  endgenerate

  assign pwr_rst_o = circ_rst[PWR_RST_POS] | ~dev_ready_o;
  assign bb_rst_o  = circ_rst[BB_RST_POS] | ~dev_ready_o;
  assign mac_rst_o = circ_rst[MAC_RST_POS] | ~dev_ready_o;

  // MAC reset also clears the control registers, synchronously
  assign mac_rst_n = ~soft_go[MAC_RST_POS];

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0] radio_q;
  logic [7:0] chan_q;

  // Radio control register; reset by POR, pin or MAC reset
  always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      radio_q <= RADIO_CTRL_RST;
    end else if (!mac_rst_n) begin
      radio_q <= RADIO_CTRL_RST;
    end else if (wr_radio) begin
      radio_q <= hwdata[7:0] & RADIO_MASK;
    end
  end

  // Channel selection; power and baseband resets leave it alone
  always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      chan_q <= CHANNEL_CFG_RST;
    end else if (!mac_rst_n) begin
      chan_q <= CHANNEL_CFG_RST;
    end else if (wr_chan) begin
      chan_q <= hwdata[7:0];
    end
  end

  // Radio state machine held while the bit is one, released on zero
  assign rfsm_rst_o      = radio_q[RFSM_RST_POS] | ~dev_ready_o;
  assign channel_cfg_o   = chan_q;
  assign radio_mode_o    = radio_q[1:0];
  assign wake_count_hi_o = radio_q[4:3];

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rd_d;

  // Software reset bits read back as pending pulses, so they self-clear
  always_comb begin
    rd_d = 32'h00000000;
    if (hit(ap_addr_q, SOFT_RESET_ADDR)) begin
      rd_d = {29'h00000000, circ_rst[PWR_RST_POS], circ_rst[BB_RST_POS],
              circ_rst[MAC_RST_POS]};
    end else if (hit(ap_addr_q, RADIO_CTRL_ADDR)) begin
      rd_d = {24'h000000, radio_q};
    end else if (hit(ap_addr_q, CHANNEL_CFG_ADDR)) begin
      rd_d = {24'h000000, chan_q};
    end else if (hit(ap_addr_q, RESET_STATUS_ADDR)) begin
      rd_d = {27'h0000000, rfsm_rst_o, circ_rst, dev_ready_o} & 32'h0000001f;
    end
  end

  assign hrdata = ap_rd_q ? rd_d : 32'h00000000;
endmodule : trc_reset_ctrl

// ===== bench/trc_reset_properties.sv
// Port checks for the transceiver reset control block
`timescale 1ns/100ps
module trc_reset_checker
  import trc_pkg::*;
#(
  parameter int unsigned RELEASE_CNT = 20,
  parameter int unsigned PULSE_LEN   = 4
) (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        ext_reset_n_i,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        dev_ready_o,
  input wire logic        pwr_rst_o,
  input wire logic        bb_rst_o,
  input wire logic        mac_rst_o,
  input wire logic        rfsm_rst_o,
  input wire logic [7:0]  channel_cfg_o,
  input wire logic [1:0]  radio_mode_o
);
  localparam int LO = RELEASE_CNT - 6;
  localparam int HI = RELEASE_CNT - 1;
  logic take, sr_q, rc_q;
  assign take = hsel && hready && htrans[1] && hwrite && dev_ready_o;
  // Marks the data phase of soft reset and radio control writes
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_q <= 1'b0;
      rc_q <= 1'b0;
    end else begin
      sr_q <= take && (haddr == 32'(SOFT_RESET_ADDR));
      rc_q <= take && (haddr == 32'(RADIO_CTRL_ADDR));
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_pulse(r);
    r [*4] ##1 !r;
  endsequence
  property p_hold;
    !ext_reset_n_i |-> !dev_ready_o && pwr_rst_o && bb_rst_o && mac_rst_o && rfsm_rst_o
      && channel_cfg_o == CHANNEL_CFG_RST;
  endproperty
  property p_release;
    $rose(ext_reset_n_i) |-> (!dev_ready_o) [*8] ##[LO:HI] $rose(dev_ready_o);
  endproperty
  property p_only;
    sr_q |=> mac_rst_o == $past(hwdata[MAC_RST_POS]) && bb_rst_o == $past(hwdata[BB_RST_POS])
      && pwr_rst_o == $past(hwdata[PWR_RST_POS]);
  endproperty
  property p_mac; sr_q && hwdata[MAC_RST_POS] |=> s_pulse(mac_rst_o); endproperty
  property p_bb; sr_q && hwdata[BB_RST_POS] |=> s_pulse(bb_rst_o); endproperty
  property p_pwr; sr_q && hwdata[PWR_RST_POS] |=> s_pulse(pwr_rst_o); endproperty
  property p_mac_clear;
    sr_q && hwdata[MAC_RST_POS] |=> channel_cfg_o == CHANNEL_CFG_RST && radio_mode_o == 2'b00;
  endproperty
  property p_keep;
    sr_q && !hwdata[MAC_RST_POS] |=> $stable(channel_cfg_o) && $stable(radio_mode_o);
  endproperty
  property p_rfsm;
    rc_q |=> rfsm_rst_o == $past(hwdata[RFSM_RST_POS]) && radio_mode_o == $past(hwdata[1:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("pin low without full reset");
  a_release: assert property (p_release) else $error("release delay off");
  a_mac: assert property (p_mac) else $error("mac reset pulse wrong");
  a_bb: assert property (p_bb) else $error("baseband reset pulse wrong");
  a_pwr: assert property (p_pwr) else $error("power reset pulse wrong");
  a_mac_clear: assert property (p_mac_clear) else $error("registers not cleared");
  a_keep: assert property (p_keep) else $error("registers lost");
  a_rfsm: assert property (p_rfsm) else $error("radio fsm reset wrong");
  a_only: assert property (p_only) else $error("unrequested circuit reset");
endmodule : trc_reset_checker

// ===== bench/trc_host_model.sv
// Host model: drives the reset pin and makes single AHB-Lite transfers
`timescale 1ns/100ps
module trc_host_model #(
  parameter int unsigned START_WAIT = 10,
  parameter int unsigned CAL_WAIT   = 96
) (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] hrdata_i,
  input  wire logic        hready_i,
  input  wire logic        dev_ready_i,
  output logic             ext_reset_n_o,
  output logic             hsel_o,
  output logic      [31:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [2:0]  hsize_o,
  output logic      [31:0] hwdata_o
);
  // Idle bus, pin released
  initial begin
    ext_reset_n_o = 1'b1;
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end
  // Value standing at the edge where hready is high
  task automatic wait_ready(output logic [31:0] q);
    logic r;
    do begin
      @(negedge core_clk_i);
      r = hready_i;
      q = hrdata_i;
      @(posedge core_clk_i);
    end while (r !== 1'b1);
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel_o <= 1'b1;
    htrans_o <= 2'b10;
    haddr_o <= a;
    hwrite_o <= w;
    wait_ready(q);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= d;
    wait_ready(q);
    hwdata_o <= ~d; // No stale data once released
  endtask : xfer
  task automatic pin_reset(input int n);
    ext_reset_n_o <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    ext_reset_n_o <= 1'b1;
  endtask : pin_reset
  task automatic settle(output int n);
    n = 0;
    while (dev_ready_i !== 1'b1 && n < 1000) begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (START_WAIT) @(posedge core_clk_i);
  endtask : settle
  task automatic rf_retune(input logic [7:0] ch);
    logic [31:0] q;
    xfer(1'b1, 32'(trc_pkg::CHANNEL_CFG_ADDR), 32'(ch), q);
    xfer(1'b1, 32'(trc_pkg::RADIO_CTRL_ADDR), 32'h04, q);
    xfer(1'b1, 32'(trc_pkg::RADIO_CTRL_ADDR), 32'h00, q);
    repeat (CAL_WAIT) @(posedge core_clk_i);
  endtask : rf_retune
endmodule : trc_host_model

// ===== bench/test_transceiver_reset_control.sv
// Testbench for the transceiver reset control block
`timescale 1ns/100ps
module test_transceiver_reset_control;
  import trc_pkg::*;
  localparam int REL = 20;
  logic        core_clk_i, nrst_i, ext_reset_n_i, hsel, hwrite, hreadyout, hresp;
  logic        dev_ready_o, pwr_rst_o, bb_rst_o, mac_rst_o, rfsm_rst_o;
  logic [31:0] haddr, hwdata, hrdata, q, want;
  logic [7:0]  channel_cfg_o;
  logic [2:0]  hsize;
  logic [1:0]  htrans, radio_mode_o, wake_count_hi_o;
  logic [2:0]  codes[4] = '{3'h4, 3'h2, 3'h1, 3'h7};
  int          n, n_errors = 0, checked = 0;
  trc_reset_ctrl #(.RELEASE_CNT(REL), .PULSE_LEN(4)) u_dut (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .ext_reset_n_i(ext_reset_n_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dev_ready_o(dev_ready_o),
    .pwr_rst_o(pwr_rst_o), .bb_rst_o(bb_rst_o), .mac_rst_o(mac_rst_o),
    .rfsm_rst_o(rfsm_rst_o), .channel_cfg_o(channel_cfg_o), .radio_mode_o(radio_mode_o),
    .wake_count_hi_o(wake_count_hi_o));
  trc_host_model u_host (.core_clk_i(core_clk_i), .hrdata_i(hrdata), .hready_i(hreadyout),
    .dev_ready_i(dev_ready_o), .ext_reset_n_o(ext_reset_n_i), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));
  // 50 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d);
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic summarize;
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // Main sequence of bus and pin scenarios
  initial begin
    nrst_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(32'(RESET_STATUS_ADDR));
    chk(q, 32'h0);
    u_host.settle(n);
    chk(32'(n >= REL - 4 && n <= REL + 6), 32'h1);
    rd(32'(CHANNEL_CFG_ADDR));
    chk(q, 32'(CHANNEL_CFG_RST));
    rd(32'(RADIO_CTRL_ADDR));
    chk(q, 32'(RADIO_CTRL_RST));
    rd(32'(RESET_STATUS_ADDR));
    chk(q, 32'h1);
    foreach (codes[i]) begin
      wr(32'(CHANNEL_CFG_ADDR), 32'h13);
      wr(32'(RADIO_CTRL_ADDR), 32'h1b);
      wr(32'(SOFT_RESET_ADDR), 32'(codes[i]));
      rd(32'(SOFT_RESET_ADDR));
      chk(q, 32'(codes[i]));
      repeat (6) @(posedge core_clk_i);
      rd(32'(SOFT_RESET_ADDR));
      chk(q, 32'h0);
      want = codes[i][MAC_RST_POS] ? 32'h00000000 : 32'h0000013f;
      chk({20'h00000, channel_cfg_o, wake_count_hi_o, radio_mode_o}, want);
    end
    u_host.rf_retune(8'h23);
    chk({23'h000000, channel_cfg_o, rfsm_rst_o}, 32'h00000046);
    wr(32'h4, 32'hff);
    rd(32'h4);
    chk(q, 32'h00000000);
    chk({30'h00000000, hreadyout, hresp}, 32'h00000002);
    chk({24'h000000, channel_cfg_o}, 32'h00000023);
    u_host.pin_reset(5);
    chk({23'h000000, dev_ready_o, channel_cfg_o}, 32'h00000000);
    u_host.settle(n);
    chk(32'(n >= REL - 4 && n <= REL + 6), 32'h1);
    summarize();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    summarize();
  end
endmodule : test_transceiver_reset_control
bind trc_reset_ctrl trc_reset_checker #(.RELEASE_CNT(RELEASE_CNT), .PULSE_LEN(PULSE_LEN)) u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ext_reset_n_i(ext_reset_n_i), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .dev_ready_o(dev_ready_o), .pwr_rst_o(pwr_rst_o), .bb_rst_o(bb_rst_o),
  .mac_rst_o(mac_rst_o), .rfsm_rst_o(rfsm_rst_o), .channel_cfg_o(channel_cfg_o),
  .radio_mode_o(radio_mode_o));
